// *** core/rscl_strap_latch.sv ***
/*
  Reset strap configuration latch of a four-port hub: samples the
  configuration straps after reset release, derives power management,
  ganged mode, indicator support and the serial target address, drives
  the upstream SuperSpeed status and the port 0 power enable, and shows
  all of it on an Avalon-MM slave with waitrequest.
  Assumes strap pins held by board resistors, a hub mode level from core
  logic on clk_in, and a synchronous active-high reset.
*/
`include "rscl_cfg.svh"

// Operation
// - SuperSpeed status high in SuperSpeed mode
// - SuperSpeed status low otherwise
// - Latch power strap; low enables management
// - Managed port power through port0 enable
// - Serial mode: address bit1 from power strap
// - Address bits 2,3 fixed one, straps override
// - Latch ganged strap; high means supported
// - Serial mode: address bit2 from ganged strap
// - Latch indicator strap for LED support
// - Indicator low enables LEDs, high disables
// - Serial mode: address bit3 from indicator
module rscl_strap_latch #(
  parameter int SETTLE_CYCLES              = `RSCL_SETTLE_CYCLES,
  parameter logic [`RSCL_TADDR_W-1:0] BASE = `RSCL_TADDR_BASE
) (
  // Clock and reset
  input  wire logic                     clk_in,
  input  wire logic                     reset_in,
  // Strap pins
  input  wire rscl_pkg::rscl_strap_type strap_in,
  // Hub state from core logic
  input  wire logic                     hub_superspeed_mode_in,
  input  wire logic                     port_power_request_in,
  // Status and control outputs
  output logic                          upstream_ss_status_out,
  output logic                          port0_power_on_charge_enable_out,
  output rscl_pkg::rscl_cfg_type        config_out,
  output logic                          config_valid_out,
  // Avalon-MM slave
  input  wire rscl_pkg::rscl_av_req_type av_req_in,
  output rscl_pkg::rscl_av_rsp_type     av_rsp_out
);
  import rscl_pkg::*;

  localparam int CNT_W = $clog2(SETTLE_CYCLES + 1);
  localparam logic [CNT_W-1:0] SETTLE_LAST = CNT_W'(SETTLE_CYCLES - 1);

  // Filtered strap levels
  rscl_strap_type           pins_sync;
  // Capture sequencing
  rscl_state_type           state_ff;
  rscl_state_type           nxt_state;
  logic [CNT_W-1:0]         settle_cnt_ff;
  // Latched settings
  rscl_cfg_type             cfg_ff;
  rscl_cfg_type             nxt_cfg;
  logic                     valid_ff;
  // Outputs from flops
  logic                     ss_status_ff;
  logic                     port0_power_ff;
  // Software control
  logic                     port0_sw_req_ff;
  // Bus handshake
  logic                     ack_ff;
  logic [`RSCL_DATA_W-1:0]  rdata_ff;
  logic                     bus_req;
  logic                     wr_take;
  logic                     rd_load;

  // Register decode for the read path; writes compare the address directly
  function automatic logic [1:0] reg_index(input logic [`RSCL_ADDR_W-1:0] addr);
    reg_index = addr[3:2];
  endfunction : reg_index

  // Checks that a byte offset names a mapped word
  function automatic logic is_mapped(input logic [`RSCL_ADDR_W-1:0] addr);
    is_mapped = (addr[1:0] == 2'h0);
  endfunction : is_mapped

  // Pin synchroniser for all four straps
  rscl_sync3 #(
    .WIDTH (4)
  ) u_sync (
    .clk_in    (clk_in),
    .reset_in  (reset_in),
    .async_in  (strap_in),
    .level_out (pins_sync)
  );

  // Next capture state: settle, capture once, then hold
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      RSCL_SETTLE: begin
        // Wait for the synchroniser and the board level to settle
        if (settle_cnt_ff == SETTLE_LAST) begin
          nxt_state = RSCL_CAPTURE;
        end
      end
      RSCL_CAPTURE: begin
        // One capture cycle only
        nxt_state = RSCL_HOLD;
      end
      RSCL_HOLD: begin
        // Leave only by reset
        nxt_state = RSCL_HOLD;
      end
      default: begin
        // Illegal code returns to a fresh capture
        nxt_state = RSCL_SETTLE;
      end
    endcase
  end

  // Capture state register
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      state_ff <= RSCL_SETTLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Settle counter after reset release
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      settle_cnt_ff <= '0;
    end else if (state_ff == RSCL_SETTLE) begin
      settle_cnt_ff <= settle_cnt_ff + CNT_W'(1);
    end
  end

  // Settings decoded from the filtered straps
  always_comb begin
    nxt_cfg             = '0;
    // Low level on the power strap enables management
    nxt_cfg.full_pm_en  = ~pins_sync.full_power_mgmt_strap_n;
    // High level on the ganged strap means supported
    nxt_cfg.ganged_en   = pins_sync.gang_mode_addr_bit2_strap;
    // Low level on the indicator strap enables LEDs
    nxt_cfg.ind_led_en  = ~pins_sync.indicator_led_addr_bit3_strap;
    // Serial target mode selected by a low select strap
    nxt_cfg.serial_mode = ~pins_sync.serial_mgmt_select_n;
    // Fixed ones on bits 2 and 3 outside serial mode
    nxt_cfg.target_addr = BASE | `RSCL_TADDR_FIXED;
    if (nxt_cfg.serial_mode) begin
      // Straps override the fixed bits in serial mode
      nxt_cfg.target_addr[1] = pins_sync.full_power_mgmt_strap_n;
      nxt_cfg.target_addr[2] = pins_sync.gang_mode_addr_bit2_strap;
      nxt_cfg.target_addr[3] = pins_sync.indicator_led_addr_bit3_strap;
    end
  end

  // Latched settings, written once per reset
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      cfg_ff <= '0;
    end else if (state_ff == RSCL_CAPTURE) begin
      cfg_ff <= nxt_cfg;
    end
  end

  // Settings valid flag
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      valid_ff <= 1'b0;
    end else if (state_ff == RSCL_CAPTURE) begin
      valid_ff <= 1'b1;
    end
  end

  // Upstream SuperSpeed connection status
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      ss_status_ff <= 1'b0;
    end else if (hub_superspeed_mode_in) begin
      ss_status_ff <= 1'b1;
    end else begin
      ss_status_ff <= 1'b0;
    end
  end

  // Port 0 power: switched under management, else on once valid
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      port0_power_ff <= 1'b0;
    end else if (!valid_ff) begin
      // Ports stay off until the settings are known
      port0_power_ff <= 1'b0;
    end else if (cfg_ff.full_pm_en) begin
      // Core request or software request turns the port on
      port0_power_ff <= port_power_request_in | port0_sw_req_ff;
    end else begin
      // Without management the port is always powered
      port0_power_ff <= 1'b1;
    end
  end

  // Bus request seen and the answering cycle
  assign bus_req = av_req_in.read | av_req_in.write;
  assign wr_take = av_req_in.write & ack_ff;
  assign rd_load = av_req_in.read & ~ack_ff;

  // One wait cycle, then answer
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= bus_req & ~ack_ff;
    end
  end

  // Software port power request
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      port0_sw_req_ff <= `RSCL_CTRL_RESET;
    end else if (wr_take && is_mapped(av_req_in.address)
                 && av_req_in.address == `RSCL_OFS_CTRL
                 && av_req_in.byteenable[0]) begin
      // Write lands only at the edge with waitrequest low
      port0_sw_req_ff <= av_req_in.writedata[`RSCL_CT_PORT0_REQ];
    end
  end

  // Read data, loaded in the wait cycle and standing at the answer
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      rdata_ff <= '0;
    end else if (rd_load) begin
      rdata_ff <= '0;
      if (is_mapped(av_req_in.address)) begin
        unique case (reg_index(av_req_in.address))
          2'h0: begin
            // Latched settings and live status
            rdata_ff[`RSCL_ST_FULL_PM]     <= cfg_ff.full_pm_en;
            rdata_ff[`RSCL_ST_GANGED]      <= cfg_ff.ganged_en;
            rdata_ff[`RSCL_ST_IND_LED]     <= cfg_ff.ind_led_en;
            rdata_ff[`RSCL_ST_SERIAL_MODE] <= cfg_ff.serial_mode;
            rdata_ff[`RSCL_ST_CAPTURED]    <= valid_ff;
            rdata_ff[`RSCL_ST_SS_STATUS]   <= ss_status_ff;
            rdata_ff[`RSCL_ST_PORT0_POWER] <= port0_power_ff;
          end
          2'h1: begin
            // Control readback
            rdata_ff[`RSCL_CT_PORT0_REQ] <= port0_sw_req_ff;
          end
          2'h2: begin
            // Target address in the low bits
            rdata_ff[`RSCL_TADDR_W-1:0] <= cfg_ff.target_addr;
          end
          2'h3: begin
            // Live filtered strap levels
            rdata_ff[3:0] <= pins_sync;
          end
        endcase
      end
    end
  end

  // Output drive
  assign upstream_ss_status_out           = ss_status_ff;
  assign port0_power_on_charge_enable_out = port0_power_ff;
  assign config_out                       = cfg_ff;
  assign config_valid_out                 = valid_ff;
  assign av_rsp_out.readdata              = rdata_ff;
  assign av_rsp_out.waitrequest           = bus_req & ~ack_ff;

endmodule : rscl_strap_latch

// *** pkg/rscl_cfg.svh ***
/*
  Constants of the reset strap configuration latch: register offsets,
  field positions, reset values and timing counts.
  Assumes it is included by bare name from the package and the core.
*/
`ifndef RSCL_CFG_SVH
`define RSCL_CFG_SVH

// Core clock period and strap settle time after reset release
`define RSCL_CLK_PERIOD_NS    10
`define RSCL_SETTLE_NS        50
// Least time rounds up to whole cycles
`define RSCL_SETTLE_CYCLES    ((`RSCL_SETTLE_NS + `RSCL_CLK_PERIOD_NS - 1) / `RSCL_CLK_PERIOD_NS)

// Bus geometry
`define RSCL_ADDR_W           4
`define RSCL_DATA_W           32

// Register byte offsets
`define RSCL_OFS_STATUS       4'h0
`define RSCL_OFS_CTRL         4'h4
`define RSCL_OFS_ADDR         4'h8
`define RSCL_OFS_PINS         4'hc

// STATUS field positions
`define RSCL_ST_FULL_PM       0
`define RSCL_ST_GANGED        1
`define RSCL_ST_IND_LED       2
`define RSCL_ST_SERIAL_MODE   3
`define RSCL_ST_CAPTURED      4
`define RSCL_ST_SS_STATUS     5
`define RSCL_ST_PORT0_POWER   6

// CTRL field positions and reset value
`define RSCL_CT_PORT0_REQ     0
`define RSCL_CTRL_RESET       1'h0

// Target address: width, base value and fixed-one bits
`define RSCL_TADDR_W          7
`define RSCL_TADDR_BASE       7'h40
`define RSCL_TADDR_FIXED      7'h0c

`endif

// *** pkg/rscl_pkg.sv ***
/*
  Types of the reset strap configuration latch: bus carriers, the strap
  bundle, the latched configuration and the capture states.
  Assumes rscl_cfg.svh is on the include path.
*/
`include "rscl_cfg.svh"

package rscl_pkg;

  // Avalon-MM request from the master
  typedef struct packed {
    logic [`RSCL_ADDR_W-1:0]   address;
    logic                      read;
    logic                      write;
    logic [`RSCL_DATA_W-1:0]   writedata;
    logic [`RSCL_DATA_W/8-1:0] byteenable;
  } rscl_av_req_type;

  // Avalon-MM answer to the master
  typedef struct packed {
    logic [`RSCL_DATA_W-1:0] readdata;
    logic                    waitrequest;
  } rscl_av_rsp_type;

  // Strap pin levels as seen on the board
  typedef struct packed {
    logic full_power_mgmt_strap_n;
    logic gang_mode_addr_bit2_strap;
    logic indicator_led_addr_bit3_strap;
    logic serial_mgmt_select_n;
  } rscl_strap_type;

  // Settings latched once after reset release
  typedef struct packed {
    logic                     full_pm_en;
    logic                     ganged_en;
    logic                     ind_led_en;
    logic                     serial_mode;
    logic [`RSCL_TADDR_W-1:0] target_addr;
  } rscl_cfg_type;

  // Capture sequence, Gray coded along the path
  typedef enum logic [1:0] {
    RSCL_SETTLE  = 2'b00,
    RSCL_CAPTURE = 2'b01,
    RSCL_HOLD    = 2'b11
  } rscl_state_type;

endpackage : rscl_pkg

// *** core/rscl_sync3.sv ***
/*
  Three-stage input synchroniser with agreement filter.
  Assumes asynchronous inputs and one core clock with synchronous reset.
*/
module rscl_sync3 #(
  parameter int WIDTH = 4
) (
  // Clock and reset
  input  wire logic             clk_in,
  input  wire logic             reset_in,
  // Raw and filtered levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] level_out
);

  logic [WIDTH-1:0] meta_ff;   // First stage, read only by the second
  logic [WIDTH-1:0] sync2_ff;  // Second stage
  logic [WIDTH-1:0] sync3_ff;  // Third stage
  logic [WIDTH-1:0] level_ff;  // Filtered level

  // Shift chain
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      meta_ff  <= '0;
      sync2_ff <= '0;
      sync3_ff <= '0;
    end else begin
      meta_ff  <= async_in;
      sync2_ff <= meta_ff;
      sync3_ff <= sync2_ff;
    end
  end

  // A bit changes only once the second and third stages agree
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      level_ff <= '0;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (sync2_ff[i] == sync3_ff[i]) begin
          level_ff[i] <= sync3_ff[i];
        end
      end
    end
  end

  assign level_out = level_ff;

endmodule : rscl_sync3

// *** dv/rscl_board_straps.sv ***
/*
  Board side of the strap pins: a jumper per pin sets its level, an
  unfitted pin rests at its pull-up.
  Assumes the bench changes jumpers only on a rising clock edge.
*/
module rscl_board_straps
  import rscl_pkg::*;
(
  // Jumper fit and level, msb is the power strap
  input  wire logic [3:0] fit_in,
  input  wire logic [3:0] level_in,
  // Pin levels seen by the hub
  output rscl_strap_type  strap_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // Open pins float to the pull-up, never to the last driven level
  assign strap_out = level_in | ~fit_in;
endmodule : rscl_board_straps

// *** dv/rscl_strap_latch_properties.sv ***
/*
  Port checker of the strap latch: status follow, capture timing,
  address derivation, port power and bus wait.
  Assumes binding onto rscl_strap_latch with its parameters.
*/
`include "rscl_cfg.svh"
module rscl_strap_latch_properties
  import rscl_pkg::*;
#(
  parameter int                       SETTLE_CYCLES = `RSCL_SETTLE_CYCLES,
  parameter logic [`RSCL_TADDR_W-1:0] BASE          = `RSCL_TADDR_BASE
) (
  // Clock and reset
  input wire logic            clk_in,
  input wire logic            reset_in,
  // Watched ports
  input wire rscl_strap_type  strap_in,
  input wire logic            hub_superspeed_mode_in,
  input wire logic            port_power_request_in,
  input wire logic            upstream_ss_status_out,
  input wire logic            port0_power_on_charge_enable_out,
  input wire rscl_cfg_type    config_out,
  input wire logic            config_valid_out,
  input wire rscl_av_req_type av_req_in,
  input wire rscl_av_rsp_type av_rsp_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  wire req_on = av_req_in.read | av_req_in.write;  // Bus request present
  wire on     = config_valid_out;                  // Settings captured
  wire ser    = on & config_out.serial_mode;       // Captured in serial mode
  // Reset release, then the quiet settle span
  sequence s_release; $fell(reset_in); endsequence
  sequence s_settle; !config_valid_out [*5]; endsequence
  a_cap_time: assert property (s_release |-> s_settle ##[1:3] on)
    else $error("capture not seen after settle");
  a_cfg_hold: assert property ($past(on) |-> on && $stable(config_out))
    else $error("captured settings moved");
  a_addr_fixed: assert property (on && !ser |-> config_out.target_addr == (BASE | `RSCL_TADDR_FIXED))
    else $error("target address wrong outside serial mode");
  a_addr_bit1: assert property (ser |-> config_out.target_addr[1] == !config_out.full_pm_en)
    else $error("address bit 1 not from power strap");
  a_addr_bit2: assert property (ser |-> config_out.target_addr[2] == config_out.ganged_en)
    else $error("address bit 2 not from gang strap");
  a_addr_bit3: assert property (ser |-> config_out.target_addr[3] == !config_out.ind_led_en)
    else $error("address bit 3 not from indicator strap");
  a_ss_high: assert property ($past(hub_superspeed_mode_in) && !$past(reset_in)
    |-> upstream_ss_status_out) else $error("status low in SuperSpeed mode");
  a_ss_low: assert property (!$past(hub_superspeed_mode_in) |-> !upstream_ss_status_out)
    else $error("status high outside SuperSpeed mode");
  a_port0_free: assert property (on && $past(on) && !config_out.full_pm_en
    |-> port0_power_on_charge_enable_out) else $error("port power off unmanaged");
  a_port0_req: assert property (on && $past(on) && config_out.full_pm_en
    && $past(port_power_request_in) |-> port0_power_on_charge_enable_out)
    else $error("port power ignores request");
  a_wait_one: assert property (req_on && av_rsp_out.waitrequest |=> !av_rsp_out.waitrequest)
    else $error("more than one wait cycle");
endmodule : rscl_strap_latch_properties

bind rscl_strap_latch rscl_strap_latch_properties #(
  .SETTLE_CYCLES(SETTLE_CYCLES), .BASE(BASE)
) i_rscl_strap_latch_properties (
  .clk_in(clk_in), .reset_in(reset_in), .strap_in(strap_in),
  .hub_superspeed_mode_in(hub_superspeed_mode_in),
  .port_power_request_in(port_power_request_in),
  .upstream_ss_status_out(upstream_ss_status_out),
  .port0_power_on_charge_enable_out(port0_power_on_charge_enable_out),
  .config_out(config_out), .config_valid_out(config_valid_out),
  .av_req_in(av_req_in), .av_rsp_out(av_rsp_out)
);

// *** dv/rscl_strap_latch_tb_top.sv ***
/*
  Bench of the strap latch: all sixteen jumper levels with random fit, register reads, control
  writes, refused writes and strap changes after capture.
  Assumes the checker binds itself and the board model drives the pins.
*/
`include "rscl_cfg.svh"
module rscl_strap_latch_tb_top
  import rscl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [6:0] BASE = `RSCL_TADDR_BASE;  // Design default
  logic clk_in = 0, reset_in = 1, hub_ss = 0, pwr_req = 0, seen = 0;
  logic [3:0] fit = 4'h0, lvl = 4'h0;  // Board jumpers
  logic valid, ss_out, port0;
  rscl_strap_type strap;
  rscl_av_req_type req = '0;
  rscl_av_rsp_type rsp;
  rscl_cfg_type cfg;
  logic [31:0] q_rd[$];   // Expected read answers
  rscl_cfg_type q_cfg[$]; // Expected captures
  int n_mismatch = 0, check_count = 0;

  rscl_board_straps i_rscl_board_straps (.fit_in(fit), .level_in(lvl), .strap_out(strap));
  rscl_strap_latch i_rscl_strap_latch (
    .clk_in(clk_in), .reset_in(reset_in), .strap_in(strap),
    .hub_superspeed_mode_in(hub_ss), .port_power_request_in(pwr_req),
    .upstream_ss_status_out(ss_out), .port0_power_on_charge_enable_out(port0),
    .config_out(cfg), .config_valid_out(valid), .av_req_in(req), .av_rsp_out(rsp)
  );

  initial forever #5 clk_in = ~clk_in;

  task automatic chk(string what, logic [31:0] e, logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  task automatic chk_cfg(rscl_cfg_type e, rscl_cfg_type g);
    chk("config", {21'h0, e}, {21'h0, g});
  endtask : chk_cfg

  // One bus transfer, held until waitrequest is seen low
  task automatic bus(logic rd, logic [3:0] a, logic [31:0] d, logic [3:0] be);
    int n = 0;
    @(posedge clk_in);
    req <= '{address: a, read: rd, write: !rd, writedata: d, byteenable: be};
    // Request stands until waitrequest is sampled low at a rising edge
    do begin
      @(posedge clk_in);
      n++;
    end while (rsp.waitrequest !== 1'b0 && n < 50);
    chk("waitrequest", 32'h0, {31'h0, rsp.waitrequest});
    // Released only after the answering edge
    req <= '0;
  endtask : bus

  task automatic rd(logic [3:0] a, logic [31:0] e);
    q_rd.push_back(e);
    bus(1'b1, a, 32'h0, 4'hf);
  endtask : rd

  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : finish_test

  // Compare each capture and each read answer against the oldest note
  always @(posedge clk_in) begin
    if (reset_in) seen = 0;
    else if (valid === 1'b1 && !seen) begin
      seen = 1;
      chk_cfg(q_cfg.pop_front(), cfg);
    end
    if (req.read && rsp.waitrequest === 1'b0) chk("readdata", q_rd.pop_front(), rsp.readdata);
  end

  // Watchdog
  initial begin
    #200000;
    n_mismatch++;
    finish_test();
  end

  initial begin
    rscl_cfg_type e;
    logic [3:0] p;
    logic [31:0] st;
    void'($urandom(25351));
    for (int s = 0; s < 16; s++) begin
      @(posedge clk_in);
      reset_in <= 1;
      lvl <= s[3:0];
      fit <= 4'($urandom);
      hub_ss <= 1'($urandom);
      pwr_req <= 1'($urandom);
      repeat (12) @(posedge clk_in);
      p = lvl | ~fit;
      e.full_pm_en = !p[3];
      e.ganged_en = p[2];
      e.ind_led_en = !p[1];
      e.serial_mode = !p[0];
      e.target_addr = p[0] ? (BASE | `RSCL_TADDR_FIXED) : {BASE[6:4], p[1], p[2], p[3], BASE[0]};
      q_cfg.push_back(e);
      reset_in <= 0;
      for (int i = 0; i < 20 && !seen; i++) @(negedge clk_in);
      @(posedge clk_in);
      lvl <= 4'($urandom);  // Later pin changes must be ignored
      repeat (8) @(posedge clk_in);
      chk("ss_status pin", {31'h0, hub_ss}, {31'h0, ss_out});
      chk("port0 pin", {31'h0, !e.full_pm_en | pwr_req}, {31'h0, port0});
      st = {25'h0, !e.full_pm_en | pwr_req, hub_ss, 1'b1, e.serial_mode, e.ind_led_en,
            e.ganged_en, e.full_pm_en};
      rd(4'h0, st);
      rd(4'h8, {25'h0, e.target_addr});
      rd(4'hc, {28'h0, lvl | ~fit});
      rd(4'h4, 32'h0);
      bus(1'b0, 4'h4, 32'h1, 4'h0);
      rd(4'h4, 32'h0);
      bus(1'b0, 4'h4, $urandom | 32'h1, 4'hf);
      rd(4'h4, 32'h1);
      st[6] = 1'b1;
      bus(1'b0, 4'h0, $urandom, 4'hf);
      rd(4'h0, st);
      rd(4'h6, 32'h0);
      chk("port0 pin", 32'h1, {31'h0, port0});
      // Hub mode change mid-run shows on the status pin one clock later
      hub_ss <= !hub_ss;
      repeat (2) @(posedge clk_in);
      chk("ss_status pin", {31'h0, hub_ss}, {31'h0, ss_out});
    end
    finish_test();
  end
endmodule : rscl_strap_latch_tb_top
